// ===== design/ttp_device.sv
// device end: two-wire slave that stores and resets trip thresholds
// Operation
// RULE1 - master raises guard pin before START
// RULE2 - raise: A0h, 09h/0Dh, data zero
// RULE3 - reset: A0h, 0Bh/0Fh, data zero
// RULE4 - programming starts only on valid STOP
// RULE5 - master drops guard pin after STOP
// RULE6 - no write enable latch needed
// RULE7 - reset returns threshold to floor
// RULE8 - lower threshold: reset, then raise
// RULE9 - target level present on monitor input
// RULE10 - refine by error, reset when high
// RULE11 - monitor output high above threshold
// RULE12 - no programming without voltage at START
`timescale 1ns/1ps
module ttp_device (
  input wire logic core_clk,
  input wire logic rst_b,
  ttp_link_if.device link,
  input wire logic [7:0] second_monitor_input,
  input wire logic [7:0] third_monitor_input,
  output logic second_monitor_output,
  output logic third_monitor_output,
  output logic [7:0] second_channel_threshold,
  output logic [7:0] third_channel_threshold,
  output logic prog_busy
);
  typedef enum logic [2:0] {
    TTPD_IDLE, TTPD_RX, TTPD_ACK, TTPD_WAIT_STOP, TTPD_PROG
  } ttpd_state_t;
  typedef struct packed {
    ttpd_state_t state;
    logic scl_d;
    logic sda_d;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] addr;
    logic valid;
    logic vp_at_start;
    logic ack_drv;
    logic [1:0] op;
    logic [7:0] thr2;
    logic [7:0] thr3;
    logic out2;
    logic out3;
    logic busy;
  } ttpd_s_t;
  ttpd_s_t s;
  ttpd_s_t next_s;

  // decode the byte address: bit1 raise/reset, bit2 chan, returns op code
  // op: 0 none, 1 raise ch2, 2 raise ch3, 3 reset (chan from addr)
  function automatic logic [1:0] ttpd_decode(input logic [7:0] a);
    case (a)
      ttp_pkg::ADDR_RAISE2: ttpd_decode = 2'd1;
      ttp_pkg::ADDR_RAISE3: ttpd_decode = 2'd2;
      ttp_pkg::ADDR_RESET2, ttp_pkg::ADDR_RESET3: ttpd_decode = 2'd3;
      default: ttpd_decode = 2'd0;
    endcase
  endfunction

  // strict compare shared by both monitor channels
  function automatic logic ttpd_above(input logic [7:0] level,
                                      input logic [7:0] thr);
    ttpd_above = level > thr;
  endfunction

  logic start_c;
  logic stop_c;
  logic stop_ok;
  logic scl_rise;
  logic scl_fall;
  assign start_c = s.scl_d && link.scl && s.sda_d && !link.sda;
  assign stop_c = s.scl_d && link.scl && !s.sda_d && link.sda;
  assign scl_rise = !s.scl_d && link.scl;
  assign scl_fall = s.scl_d && !link.scl;

  // a stop programs only right after the third acknowledge, with the
  // guard pin seen high at the start; a partial extra byte is refused
  assign stop_ok = s.valid && s.vp_at_start && s.byte_idx == 2'd3 &&
    s.state == TTPD_RX && s.bit_cnt == 4'h1; // RULE4 RULE12

  // slave protocol, programming and comparators
  always_comb begin
    next_s = s;
    next_s.scl_d = link.scl;
    next_s.sda_d = link.sda;
    // comparators track the stored thresholds continuously
    next_s.out2 = ttpd_above(second_monitor_input, s.thr2); // RULE11
    next_s.out3 = ttpd_above(third_monitor_input, s.thr3); // RULE11
    if (start_c && s.state != TTPD_PROG) begin
      next_s.state = TTPD_RX;
      next_s.bit_cnt = 4'd0;
      next_s.byte_idx = 2'd0;
      next_s.valid = 1'b0;
      next_s.ack_drv = 1'b0;
      next_s.vp_at_start = link.prog_voltage; // RULE12
    end else if (stop_c && s.state != TTPD_PROG) begin
      next_s.ack_drv = 1'b0;
      // clear the frame so a stray second stop cannot program again
      next_s.valid = 1'b0;
      next_s.byte_idx = 2'd0;
      // write enable latch is never consulted here
      if (stop_ok) begin // RULE4 RULE6
        next_s.state = TTPD_PROG;
        next_s.op = ttpd_decode(s.addr);
      end else begin
        next_s.state = TTPD_IDLE;
      end
    end else begin
      case (s.state)
        TTPD_IDLE: begin
          // line released between frames
          next_s.ack_drv = 1'b0;
        end
        TTPD_RX: begin
          if (scl_rise) begin
            next_s.shift = {s.shift[6:0], link.sda};
            next_s.bit_cnt = s.bit_cnt + 4'd1;
          end
          if (scl_fall && s.bit_cnt == 4'd8) begin
            next_s.bit_cnt = 4'd0;
            next_s.byte_idx = s.byte_idx + 2'd1;
            next_s.state = TTPD_ACK;
            next_s.ack_drv = 1'b1;
            case (s.byte_idx)
              2'd0: next_s.valid = s.shift == ttp_pkg::SLAVE_WRITE; // RULE2
              2'd1: begin
                next_s.addr = s.shift;
                next_s.valid = s.valid &&
                  ttpd_decode(s.shift) != 2'd0; // RULE2 RULE3
              end
              2'd2: next_s.valid = s.valid &&
                s.shift == ttp_pkg::DATA_ZERO; // RULE3
              default: begin
                next_s.valid = 1'b0; // extra byte aborts
                next_s.ack_drv = 1'b0;
              end
            endcase
            // a wrong slave or byte address is not acknowledged; the
            // data byte is, once the address was good
            if (s.byte_idx == 2'd2 ? !s.valid :
                (s.byte_idx != 2'd3 && !next_s.valid)) begin
              next_s.ack_drv = 1'b0;
              next_s.state = TTPD_WAIT_STOP;
              next_s.valid = 1'b0;
            end
          end
        end
        TTPD_ACK: begin
          // hold the low through the ninth clock so the master sees it
          if (scl_fall) begin
            next_s.ack_drv = 1'b0;
            next_s.state = TTPD_RX;
          end
        end
        TTPD_WAIT_STOP: begin
          // refused frame: stay off the line until the stop
          next_s.ack_drv = 1'b0;
        end
        TTPD_PROG: begin
          // analog level is latched when the guard pin falls
          if (!link.prog_voltage) begin // RULE5
            case (s.op)
              2'd1: next_s.thr2 = second_monitor_input; // RULE9
              2'd2: next_s.thr3 = third_monitor_input; // RULE9
              2'd3: begin
                // reset channel follows the byte address
                if (s.addr == ttp_pkg::ADDR_RESET2)
                  next_s.thr2 = ttp_pkg::FLOOR_CODE; // RULE7
                else
                  next_s.thr3 = ttp_pkg::FLOOR_CODE; // RULE7
              end
              default: ;
            endcase
            next_s.state = TTPD_IDLE;
          end
        end
        default: next_s.state = TTPD_IDLE;
      endcase
    end
    // registered so prog_busy leaves a flop directly
    next_s.busy = next_s.state == TTPD_PROG;
  end

  // single state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.state <= TTPD_IDLE;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
      // thresholds come up at the shipped default
      s.thr2 <= ttp_pkg::DEFAULT_CODE;
      s.thr3 <= ttp_pkg::DEFAULT_CODE;
    end else begin
      s <= next_s;
    end
  end

  // every output except the constant sda_dev_out leaves a flop of the state struct
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = s.ack_drv;
  assign second_monitor_output = s.out2;
  assign third_monitor_output = s.out3;
  assign second_channel_threshold = s.thr2;
  assign third_channel_threshold = s.thr3;
  assign prog_busy = s.busy;
endmodule

// ===== design/ttp_pkg.sv
// shared constants for the trip threshold programmer link
package ttp_pkg;
  localparam logic [7:0] SLAVE_WRITE = 8'hA0;
  localparam logic [7:0] ADDR_RAISE2 = 8'h09;
  localparam logic [7:0] ADDR_RAISE3 = 8'h0D;
  localparam logic [7:0] ADDR_RESET2 = 8'h0B;
  localparam logic [7:0] ADDR_RESET3 = 8'h0F;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // threshold codes: 8-bit scale, floor code stands for the nominal 1.7 V
  localparam logic [7:0] FLOOR_CODE = 8'h11;
  localparam logic [7:0] DEFAULT_CODE = 8'h12;
  // host clock divider: tick runs 0..HALF_BIT, so 9 cycles per step
  localparam logic [3:0] HALF_BIT = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
endpackage

// ===== design/ttp_link_if.sv
// two-wire link plus programming-voltage pin between the two ends
`timescale 1ns/1ps
interface ttp_link_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic prog_voltage;
  logic sda;
  // open-drain wire: low if any end drives, else pulled high
  assign sda = !((sda_host_oe && !sda_host_out) ||
                 (sda_dev_oe && !sda_dev_out));
  modport device (input scl, input sda, input prog_voltage,
    output sda_dev_out, output sda_dev_oe);
  modport host (output scl, input sda, output prog_voltage,
    output sda_host_out, output sda_host_oe);
endinterface

// ===== design/ttp_host.sv
// host end: bus master that issues raise and reset sequences
`timescale 1ns/1ps
module ttp_host (
  input wire logic core_clk,
  input wire logic rst_b,
  ttp_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_addr,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_nack
);
  typedef enum logic [2:0] {
    TTPH_IDLE, TTPH_VP, TTPH_START, TTPH_BITS, TTPH_STOP, TTPH_RELEASE
  } ttph_state_t;
  typedef struct packed {
    ttph_state_t state;
    logic [3:0] tick;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] addr;
    logic [7:0] shift;
    logic scl;
    logic sda_low;
    logic vp;
    logic nack;
    logic ready;
    logic done;
  } ttph_s_t;
  ttph_s_t s;
  ttph_s_t next_s;

  // byte to send for each position of the transaction
  function automatic logic [7:0] ttph_byte(input logic [1:0] i,
                                           input logic [7:0] a);
    case (i)
      2'd0: ttph_byte = ttp_pkg::SLAVE_WRITE; // RULE2
      2'd1: ttph_byte = a;
      default: ttph_byte = ttp_pkg::DATA_ZERO; // RULE3
    endcase
  endfunction

  logic tick_end;
  assign tick_end = s.tick == ttp_pkg::HALF_BIT;

  // sequencer, one step per tick_end, three steps per scl period in TTPH_BITS
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.tick = tick_end ? 4'd0 : s.tick + 4'd1;
    case (s.state)
      TTPH_IDLE: begin
        next_s.tick = 4'd0;
        if (cmd_valid && s.ready) begin
          next_s.addr = cmd_addr;
          next_s.ready = 1'b0;
          next_s.nack = 1'b0;
          next_s.vp = 1'b1; // RULE1
          next_s.state = TTPH_VP;
        end
      end
      TTPH_VP: if (tick_end) begin
        next_s.sda_low = 1'b1; // RULE1
        next_s.state = TTPH_START;
      end
      TTPH_START: if (tick_end) begin
        next_s.scl = 1'b0;
        next_s.byte_idx = 2'd0;
        next_s.bit_cnt = 4'd0;
        next_s.shift = ttph_byte(2'd0, s.addr);
        next_s.phase = 2'd0;
        next_s.state = TTPH_BITS;
      end
      TTPH_BITS: if (tick_end) begin
        // phase 0 set data while low, 1 raise scl, 2 lower scl
        case (s.phase)
          2'd0: begin
            next_s.sda_low = s.bit_cnt == 4'd8 ? 1'b0 : !s.shift[7];
            next_s.phase = 2'd1;
          end
          2'd1: begin
            next_s.scl = 1'b1;
            if (s.bit_cnt == 4'd8 && link.sda)
              next_s.nack = 1'b1;
            next_s.phase = 2'd2;
          end
          default: begin
            next_s.scl = 1'b0;
            next_s.phase = 2'd0;
            if (s.bit_cnt == 4'd8) begin
              next_s.bit_cnt = 4'd0;
              next_s.byte_idx = s.byte_idx + 2'd1;
              next_s.shift = ttph_byte(s.byte_idx + 2'd1, s.addr);
              if (s.byte_idx == 2'd2 || s.nack) begin
                next_s.sda_low = 1'b1;
                next_s.state = TTPH_STOP;
              end
            end else begin
              next_s.bit_cnt = s.bit_cnt + 4'd1;
              next_s.shift = {s.shift[6:0], 1'b0};
            end
          end
        endcase
      end
      TTPH_STOP: if (tick_end) begin
        if (!s.scl) begin
          next_s.scl = 1'b1;
        end else begin
          next_s.sda_low = 1'b0;
          next_s.state = TTPH_RELEASE;
        end
      end
      TTPH_RELEASE: if (tick_end) begin
        next_s.vp = 1'b0; // RULE5
        next_s.done = 1'b1;
        next_s.ready = 1'b1;
        next_s.state = TTPH_IDLE;
      end
      default: next_s.state = TTPH_IDLE;
    endcase
  end

  // single state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.state <= TTPH_IDLE;
      s.scl <= 1'b1;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.scl = s.scl;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = s.sda_low;
  assign link.prog_voltage = s.vp;
  assign cmd_ready = s.ready;
  assign cmd_done = s.done;
  assign cmd_nack = s.nack;
endmodule

// ===== sim/ttp_monitor.sv
// link checker: timing and ownership of the two-wire lines
`timescale 1ns/1ps
module ttp_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic prog_voltage
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // start and stop are sda edges with scl held high
  a_guard_at_start: assert property (
    scl && $past(scl) && $fell(sda) |-> prog_voltage)
    else $error("start without programming voltage");
  a_guard_drop: assert property (
    scl && $past(scl) && $rose(sda) && prog_voltage
      |-> ##[1:20] !prog_voltage)
    else $error("guard pin not lowered after stop");
  a_idle_clock_high: assert property (
    !prog_voltage |-> scl)
    else $error("clock toggles without programming voltage");
  a_scl_high_width: assert property (
    $rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_width: assert property (
    $fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
  a_dev_ack_edge: assert property (
    $changed(sda_dev_oe) |-> !scl)
    else $error("device changed data with clock high");
  a_dev_open_drain: assert property (
    sda_dev_oe |-> !sda_dev_out)
    else $error("device drives data high");
  a_host_open_drain: assert property (
    sda_host_oe |-> !sda_host_out)
    else $error("host drives data high");
  // main scenarios reached
  c_start: cover property (scl && $past(scl) && $fell(sda));
  c_ack: cover property ($rose(sda_dev_oe));
  c_guard_fall: cover property ($fell(prog_voltage));
endmodule

// ===== sim/tb.sv
// self-checking bench: host end drives device end over the link
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb;
  logic core_clk, rst_b, cmd_valid, cmd_ready, cmd_done, cmd_nack;
  logic out2, out3, prog_busy;
  logic [7:0] cmd_addr, in2, in3, thr2, thr3;
  logic [7:0] seq [$];
  int n_mismatch = 0;
  int checks = 0;
  int exp2, exp3;
  ttp_link_if link ();
  ttp_host ttp_host_inst (.core_clk(core_clk), .rst_b(rst_b),
    .link(link), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_nack(cmd_nack));
  ttp_device ttp_device_inst (.core_clk(core_clk), .rst_b(rst_b),
    .link(link), .second_monitor_input(in2),
    .third_monitor_input(in3), .second_monitor_output(out2),
    .third_monitor_output(out3), .second_channel_threshold(thr2),
    .third_channel_threshold(thr3), .prog_busy(prog_busy));
  ttp_monitor ttp_monitor_inst (.core_clk(core_clk), .rst_b(rst_b),
    .scl(link.scl), .sda(link.sda), .sda_host_out(link.sda_host_out),
    .sda_host_oe(link.sda_host_oe), .sda_dev_out(link.sda_dev_out),
    .sda_dev_oe(link.sda_dev_oe), .prog_voltage(link.prog_voltage));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one command, then model update; bounded waits catch a stuck host
  task automatic do_cmd(input logic [7:0] a);
    int n;
    logic bad;
    n = 0;
    bad = 1'b1;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_addr = a;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
      if (n == 60) `CHK(thr2, exp2[7:0])
    end
    if (n >= 2000) begin
      n_mismatch++;
      $display("[ERR] %0t command never completed", $time);
    end
    case (a)
      ttp_pkg::ADDR_RAISE2: begin exp2 = in2; bad = 1'b0; end
      ttp_pkg::ADDR_RAISE3: begin exp3 = in3; bad = 1'b0; end
      ttp_pkg::ADDR_RESET2: begin
        exp2 = ttp_pkg::FLOOR_CODE;
        bad = 1'b0;
      end
      ttp_pkg::ADDR_RESET3: begin
        exp3 = ttp_pkg::FLOOR_CODE;
        bad = 1'b0;
      end
      default: bad = 1'b1;
    endcase
    repeat (3) @(negedge core_clk);
    `CHK(thr2, exp2[7:0])
    `CHK(thr3, exp3[7:0])
    `CHK(cmd_nack, bad)
    `CHK(prog_busy, 1'b0)
  endtask

  // random levels on both inputs, strict compare against thresholds
  task automatic check_outs;
    in2 = 8'($urandom);
    in3 = 8'($urandom);
    repeat (2) @(negedge core_clk);
    `CHK(out2, (int'(in2) > exp2))
    `CHK(out3, (int'(in3) > exp3))
  endtask

  // refinement: program off target, find the trip by sweeping the input
  // down, then program the previous level corrected by the error
  task automatic refine(input int tgt, input int err);
    int trip;
    int prev;
    do_cmd(ttp_pkg::ADDR_RESET2);
    prev = tgt + err;
    in2 = 8'(prev);
    do_cmd(ttp_pkg::ADDR_RAISE2);
    trip = 255;
    in2 = 8'(trip);
    repeat (2) @(negedge core_clk);
    while (out2 === 1'b1 && trip > 0) begin
      trip--;
      in2 = 8'(trip);
      repeat (2) @(negedge core_clk);
    end
    `CHK(trip, prev)
    if (trip > tgt) do_cmd(ttp_pkg::ADDR_RESET2);
    in2 = 8'(prev - (trip - tgt));
    do_cmd(ttp_pkg::ADDR_RAISE2);
    `CHK(thr2, 8'(tgt))
  endtask

  // main sequence: reset then raise per channel, plus a bad address
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr = 8'h00;
    in2 = 8'h00;
    in3 = 8'h00;
    exp2 = ttp_pkg::DEFAULT_CODE;
    exp3 = ttp_pkg::DEFAULT_CODE;
    seq = '{ttp_pkg::ADDR_RESET2, ttp_pkg::ADDR_RAISE2,
      ttp_pkg::ADDR_RESET3, ttp_pkg::ADDR_RAISE3, 8'h0C};
    void'($urandom(22));
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    `CHK(thr2, ttp_pkg::DEFAULT_CODE)
    check_outs();
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < seq.size(); i++) begin
        // target held on the input across the raise, always above floor
        in2 = 8'(18 + $urandom_range(237));
        in3 = 8'(18 + $urandom_range(237));
        do_cmd(seq[i]);
        check_outs();
      end
    end
    refine(120, 9);
    refine(120, -7);
    tally_and_finish();
  end

  // watchdog: 27 commands of some 800 cycles plus two sweeps fit inside
  initial begin
    #3ms;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
